// [rtl/pdic_consts.svh]
// Offsets, field positions, reset values and filter counts of the
// position-detect input control block.
// Assumes byte addresses on a 32-bit APB, one aligned word per register.
`ifndef PDIC_CONSTS_SVH
`define PDIC_CONSTS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define PDIC_ADDR_UPPER      12'h000
`define PDIC_ADDR_LOWER      12'h004

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define PDIC_RST_UPPER       8'h00
`define PDIC_RST_LOWER       8'h00

// ----------------------------------------------------------------------
// Upper register fields
// ----------------------------------------------------------------------
`define PDIC_WSYNC_HI        7
`define PDIC_WSYNC_LO        6
`define PDIC_FLAG_BIT        5
`define PDIC_IE_BIT          4
`define PDIC_CVAL_HI         3
`define PDIC_CVAL_LO         1
`define PDIC_POSITION_COMPARE_ENABLE_BIT        0

// ----------------------------------------------------------------------
// Lower register fields
// ----------------------------------------------------------------------
`define PDIC_POL_HI          7
`define PDIC_POL_LO          6
`define PDIC_FILT_LO         3
`define PDIC_DET_LO          0

// ----------------------------------------------------------------------
// Edge select codes
// ----------------------------------------------------------------------
`define PDIC_EDGE_NONE       2'h0
`define PDIC_EDGE_RISE       2'h1
`define PDIC_EDGE_FALL       2'h2
`define PDIC_EDGE_BOTH       2'h3

// ----------------------------------------------------------------------
// Last count of the filter counter for n = 2, 3, 4 and 5
// ----------------------------------------------------------------------
`define PDIC_FILT_LAST_N2    5'h03
`define PDIC_FILT_LAST_N3    5'h07
`define PDIC_FILT_LAST_N4    5'h0F
`define PDIC_FILT_LAST_N5    5'h1F

`endif

// [rtl/pdic_edge_detect.sv]
// Edge detector with a selectable polarity for one level.
// Assumes the level is synchronous to i_clk.
`timescale 1ns/1ps
`include "pdic_consts.svh"

module pdic_edge_detect (
    // Clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_resetn,
    // Level and polarity
    input  wire logic       i_level,
    input  wire logic [1:0] i_polarity,
    // Result
    output logic            o_hit
);

    pdic_pkg::pdic_edge_state_t s_q;
    pdic_pkg::pdic_edge_state_t s_d;

    always_comb begin
        s_d      = s_q;
        s_d.prev = i_level;
        case (i_polarity)
            `PDIC_EDGE_RISE: o_hit = i_level & ~s_q.prev;
            `PDIC_EDGE_FALL: o_hit = ~i_level & s_q.prev;
            `PDIC_EDGE_BOTH: o_hit = i_level ^ s_q.prev;
            default:         o_hit = 1'b0;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

endmodule

// [rtl/pdic_noise_filter.sv]
// Noise canceller for one sensor input, with bypass.
// Assumes the sensor level is synchronous to i_clk.
`timescale 1ns/1ps
`include "pdic_consts.svh"

module pdic_noise_filter (
    // Clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_resetn,
    // Sensor and control
    input  wire logic       i_raw,
    input  wire logic       i_filter_on,
    input  wire logic [1:0] i_len_sel,
    input  wire logic       i_clock_stopped,
    // Result
    output logic            o_level,
    output logic            o_valid
);

    pdic_pkg::pdic_filt_state_t s_q;
    pdic_pkg::pdic_filt_state_t s_d;

    function automatic logic [4:0] last_count(input logic [1:0] sel);
        case (sel)
            2'h0:    last_count = `PDIC_FILT_LAST_N2;
            2'h1:    last_count = `PDIC_FILT_LAST_N3;
            2'h2:    last_count = `PDIC_FILT_LAST_N4;
            default: last_count = `PDIC_FILT_LAST_N5;
        endcase
    endfunction

    always_comb begin
        s_d = s_q;
        if (!i_filter_on) begin // see RL9
            s_d.level = i_raw;
            s_d.cnt   = 5'h00;
            s_d.valid = 1'b1;
        end else if (i_clock_stopped) begin // see RL11
            s_d.cnt   = 5'h00;
            s_d.valid = 1'b0;
        end else if (i_raw == s_q.level) begin
            s_d.cnt   = 5'h00;
            s_d.valid = 1'b1;
        end else if (s_q.cnt == last_count(i_len_sel)) begin // see RL10
            s_d.level = i_raw;
            s_d.cnt   = 5'h00;
            s_d.valid = 1'b1;
        end else begin
            s_d.cnt   = s_q.cnt + 5'h01;
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign o_level = s_q.level;
    assign o_valid = s_q.valid;

    stop_invalid_a: assert property ( // see RL11
        @(posedge i_clk) disable iff (!i_resetn)
        (i_filter_on && i_clock_stopped) |=> !o_valid)
        else $error("Filtered input stays valid with clock stopped.");

    filter_accept_a: assert property ( // see RL10
        @(posedge i_clk) disable iff (!i_resetn)
        (i_filter_on && $changed(o_level))
            |-> $past(s_q.cnt) == last_count($past(i_len_sel)))
        else $error("Filter accepted a level before overflow.");

endmodule

// [rtl/pdic_pkg.sv]
// State types of the position-detect input control block.
// Assumes nothing of its surroundings.
package pdic_pkg;

    typedef struct packed {
        logic [4:0] cnt;
        logic       level;
        logic       valid;
    } pdic_filt_state_t;

    typedef struct packed {
        logic       prev;
    } pdic_edge_state_t;

    typedef struct packed {
        logic [7:0]  upper;
        logic [7:0]  lower;
        logic        match_prev;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
        logic        irq;
        logic        wsync;
        logic        pdet;
    } pdic_top_state_t;

endpackage

// [rtl/pdic_top.sv]
// Position-detect input control: two control registers on APB, write
// timing edge sync, bank address compare and sensor edge detection.
// Assumes all inputs are synchronous to I_CLK at 10 MHz.
//
// Operation
// RL1: Select pulse-train edge for write timing sync.
// RL2: Address equal to compare value sets flag.
// RL3: Flag and enable together raise compare interrupt.
// RL4: Writing 0 clears flag; 1 does nothing.
// RL5: Read-modify-write read returns flag as 1.
// RL6: Compare value sits in upper bits 3:1.
// RL7: Upper bit 0 enables the compare operation.
// RL8: Two bits select detection edge polarity.
// RL9: Per-input filter enable in lower bits 5:3.
// RL10: Filter accepts level only after counter overflow.
// RL11: Filtered input invalid while clock stopped.
// RL12: Lower bits 2:0 enable per-input edge detection.
// RL13: No flag setting while compare disabled.
//
// The APB register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "pdic_consts.svh"

module pdic_top (
    // Clock and reset
    input  wire logic        I_CLK,
    input  wire logic        I_RESETN,
    // APB slave
    input  wire logic        I_PSEL,
    input  wire logic        I_PENABLE,
    input  wire logic        I_PWRITE,
    input  wire logic [11:0] I_PADDR,
    input  wire logic [31:0] I_PWDATA,
    output logic      [31:0] O_PRDATA,
    output logic             O_PREADY,
    output logic             O_PSLVERR,
    // Read-modify-write marker, valid with a read setup cycle
    input  wire logic        I_RMW_READ,
    // Multi-pulse unit side
    input  wire logic [2:0]  I_BANK_READ_ADDRESS,
    input  wire logic        I_PULSE_TRAIN_GENERATOR,
    input  wire logic [1:0]  I_FILTER_LENGTH_SELECT,
    input  wire logic        I_CLOCK_STOPPED,
    // Sensor inputs
    input  wire logic        I_SENSOR_INPUT_0,
    input  wire logic        I_SENSOR_INPUT_1,
    input  wire logic        I_SENSOR_INPUT_2,
    // Events and interrupt
    output logic             O_COMPARE_IRQ,
    output logic             O_WRITE_SYNC,
    output logic             O_POSITION_DETECT
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    pdic_pkg::pdic_top_state_t s_q;
    pdic_pkg::pdic_top_state_t s_d;

    logic [2:0] sensor_raw;
    logic [2:0] sensor_level;
    logic [2:0] sensor_valid;
    logic [2:0] sensor_hit;
    logic       wsync_hit;
    logic       setup;
    logic       wr_access;
    logic       match_now;
    logic       flag_set;
    logic       flag_clear;

    assign sensor_raw = {I_SENSOR_INPUT_2, I_SENSOR_INPUT_1,
                         I_SENSOR_INPUT_0};

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    function automatic logic hits_upper(input logic [11:0] addr);
        hits_upper = (addr == `PDIC_ADDR_UPPER);
    endfunction

    function automatic logic hits_lower(input logic [11:0] addr);
        hits_lower = (addr == `PDIC_ADDR_LOWER);
    endfunction

    // ------------------------------------------------------------------
    // Sensor path: filter then edge detection
    // ------------------------------------------------------------------
    for (genvar g = 0; g < 3; g++) begin : g_sensor
        pdic_noise_filter u_filter (
            .i_clk           (I_CLK),
            .i_resetn        (I_RESETN),
            .i_raw           (sensor_raw[g]),
            .i_filter_on     (s_q.lower[`PDIC_FILT_LO + g]), // see RL9
            .i_len_sel       (I_FILTER_LENGTH_SELECT),
            .i_clock_stopped (I_CLOCK_STOPPED),
            .o_level         (sensor_level[g]),
            .o_valid         (sensor_valid[g])
        );

        pdic_edge_detect u_edge (
            .i_clk      (I_CLK),
            .i_resetn   (I_RESETN),
            .i_level    (sensor_level[g]),
            .i_polarity (s_q.lower[`PDIC_POL_HI:`PDIC_POL_LO]), // see RL8
            .o_hit      (sensor_hit[g])
        );
    end

    pdic_edge_detect u_wsync_edge (
        .i_clk      (I_CLK),
        .i_resetn   (I_RESETN),
        .i_level    (I_PULSE_TRAIN_GENERATOR),
        .i_polarity (s_q.upper[`PDIC_WSYNC_HI:`PDIC_WSYNC_LO]), // see RL1
        .o_hit      (wsync_hit)
    );

    // ------------------------------------------------------------------
    // Compare and flag
    // ------------------------------------------------------------------
    // The flag is set on the cycle a match begins, so that a software
    // clear during a standing match is not undone at once.
    assign match_now = s_q.upper[`PDIC_POSITION_COMPARE_ENABLE_BIT] // see RL7 see RL13
        & (I_BANK_READ_ADDRESS ==
           s_q.upper[`PDIC_CVAL_HI:`PDIC_CVAL_LO]); // see RL6
    assign flag_set  = match_now & ~s_q.match_prev; // see RL2

    assign setup     = I_PSEL & ~I_PENABLE;
    assign wr_access = I_PSEL & I_PENABLE & s_q.pready & I_PWRITE;
    assign flag_clear = wr_access & hits_upper(I_PADDR)
                      & ~I_PWDATA[`PDIC_FLAG_BIT]; // see RL4

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        s_d            = s_q;
        s_d.match_prev = match_now;

        // Register writes.
        if (wr_access && hits_upper(I_PADDR)) begin
            s_d.upper[`PDIC_WSYNC_HI:`PDIC_WSYNC_LO] =
                I_PWDATA[`PDIC_WSYNC_HI:`PDIC_WSYNC_LO];
            s_d.upper[`PDIC_IE_BIT:0] = I_PWDATA[`PDIC_IE_BIT:0];
        end
        if (wr_access && hits_lower(I_PADDR)) begin
            s_d.lower = I_PWDATA[7:0];
        end

        // A set in the same cycle as a clear wins.
        s_d.upper[`PDIC_FLAG_BIT] = flag_set // see RL2 see RL4
            | (s_q.upper[`PDIC_FLAG_BIT] & ~flag_clear);

        // Interrupt follows the next flag and enable.
        s_d.irq = s_d.upper[`PDIC_FLAG_BIT] // see RL3
                & s_d.upper[`PDIC_IE_BIT];

        // Write timing sync pulse.
        s_d.wsync = wsync_hit; // see RL1

        // Position detection pulse from enabled, valid inputs.
        s_d.pdet = |(sensor_hit & sensor_valid // see RL11
                     & s_q.lower[`PDIC_DET_LO +: 3]); // see RL12

        // APB answer: data and error captured in setup, ready in access.
        s_d.pready = setup;
        if (setup) begin
            s_d.pslverr = ~(hits_upper(I_PADDR) | hits_lower(I_PADDR));
            s_d.prdata  = 32'h0000_0000;
            if (!I_PWRITE && hits_upper(I_PADDR)) begin
                s_d.prdata[7:0] = s_q.upper;
                if (I_RMW_READ) begin
                    s_d.prdata[`PDIC_FLAG_BIT] = 1'b1; // see RL5
                end
            end else if (!I_PWRITE && hits_lower(I_PADDR)) begin
                s_d.prdata[7:0] = s_q.lower;
            end
        end else if (!I_PSEL) begin
            s_d.pslverr = 1'b0;
            s_d.prdata  = 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge I_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            s_q       <= '0;
            s_q.upper <= `PDIC_RST_UPPER;
            s_q.lower <= `PDIC_RST_LOWER;
        end else begin
            s_q <= s_d;
        end
    end

    assign O_PRDATA          = s_q.prdata;
    assign O_PREADY          = s_q.pready;
    assign O_PSLVERR         = s_q.pslverr;
    assign O_COMPARE_IRQ     = s_q.irq;
    assign O_WRITE_SYNC      = s_q.wsync;
    assign O_POSITION_DETECT = s_q.pdet;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    wsync_rise_a: assert property ( // see RL1
        @(posedge I_CLK) disable iff (!I_RESETN)
        (s_q.upper[7:6] == 2'h1 && $rose(I_PULSE_TRAIN_GENERATOR))
            |=> O_WRITE_SYNC)
        else $error("Rising edge missed by write sync.");

    wsync_none_a: assert property ( // see RL1
        @(posedge I_CLK) disable iff (!I_RESETN)
        (s_q.upper[7:6] == 2'h0) |=> !O_WRITE_SYNC)
        else $error("Write sync pulse with sync off.");

    match_sets_a: assert property ( // see RL2
        @(posedge I_CLK) disable iff (!I_RESETN)
        (s_q.upper[0] && !s_q.match_prev
            && I_BANK_READ_ADDRESS == s_q.upper[3:1])
            |=> s_q.upper[5])
        else $error("Compare match did not set the flag.");

    irq_gate_a: assert property ( // see RL3
        @(posedge I_CLK) disable iff (!I_RESETN)
        O_COMPARE_IRQ == (s_q.upper[5] && s_q.upper[4]))
        else $error("Interrupt disagrees with flag and enable.");

    flag_write_a: assert property ( // see RL4
        @(posedge I_CLK) disable iff (!I_RESETN)
        (wr_access && I_PADDR == 12'h000 && !flag_set)
            |=> s_q.upper[5] == ($past(s_q.upper[5]) && $past(I_PWDATA[5])))
        else $error("Flag write did not clear or keep the flag.");

    rmw_read_a: assert property ( // see RL5
        @(posedge I_CLK) disable iff (!I_RESETN)
        (setup && !I_PWRITE && I_RMW_READ && I_PADDR == 12'h000)
            |=> O_PRDATA[5] ##1 !O_PREADY)
        else $error("Read-modify-write read lost the flag bit.");

    cmp_off_a: assert property ( // see RL13
        @(posedge I_CLK) disable iff (!I_RESETN)
        !s_q.upper[0] |=> !$rose(s_q.upper[5]))
        else $error("Flag set while compare disabled.");

    detect_off_a: assert property ( // see RL8
        @(posedge I_CLK) disable iff (!I_RESETN)
        (s_q.lower[7:6] == 2'h0 || s_q.lower[2:0] == 3'h0) // see RL12
            |=> !O_POSITION_DETECT)
        else $error("Position detect pulse while detection is off.");

endmodule

// [tb/pdic_sensor_model.sv]
// Behavioural model of the three position sensors on the far side.
// Assumes the bench sets target levels just after a rising clock edge.
`timescale 1ns/1ps

module pdic_sensor_model (
    // Clock
    input  wire logic       i_clk,
    // Commands from the bench
    input  wire logic [2:0] i_target,
    input  wire logic       i_bounce,
    // Sensor levels
    output logic      [2:0] o_level
);
    logic [2:0] level_q = 3'h0;
    logic [2:0] last_q  = 3'h0;
    logic [2:0] diff_q  = 3'h0;
    logic [1:0] chat_q  = 2'h0;

    assign o_level = level_q;

    // With bouncing on, a changed line chatters for three cycles first.
    always @(posedge i_clk) begin
        last_q <= i_target;
        if (i_target != last_q) begin
            level_q <= i_target;
            diff_q  <= i_target ^ last_q;
            chat_q  <= i_bounce ? 2'h3 : 2'h0;
        end else if (chat_q != 2'h0) begin
            level_q <= level_q ^ diff_q;
            chat_q  <= chat_q - 2'h1;
        end else begin
            level_q <= i_target;
        end
    end
endmodule

// [tb/pdic_top_bench.sv]
// Self-checking bench of the position-detect input control block.
// Assumes an APB slave; the master waits for pready as long as it takes.
`timescale 1ns/1ps
`include "pdic_consts.svh"

module pdic_top_bench;
    localparam logic [11:0] up_addr = `PDIC_ADDR_UPPER;
    localparam logic [11:0] lo_addr = `PDIC_ADDR_LOWER;
    logic        clk = 1'b0;
    logic        resetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        rmw;
    logic [2:0]  bank;
    logic        ptg;
    logic [1:0]  flen;
    logic        stopped;
    logic [2:0]  target;
    logic        bounce;
    logic [2:0]  sensor;
    logic        irq;
    logic        wsync;
    logic        pdet;
    logic [31:0] rd;
    logic        err;
    int          fails;
    int          checks_done;
    int          ws_cnt;
    int          pd_cnt;
    int          n0;

    pdic_top i_pdic_top (
        .I_CLK(clk), .I_RESETN(resetn), .I_PSEL(psel),
        .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr),
        .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready),
        .O_PSLVERR(pslverr), .I_RMW_READ(rmw),
        .I_BANK_READ_ADDRESS(bank), .I_PULSE_TRAIN_GENERATOR(ptg),
        .I_FILTER_LENGTH_SELECT(flen), .I_CLOCK_STOPPED(stopped),
        .I_SENSOR_INPUT_0(sensor[0]), .I_SENSOR_INPUT_1(sensor[1]),
        .I_SENSOR_INPUT_2(sensor[2]), .O_COMPARE_IRQ(irq),
        .O_WRITE_SYNC(wsync), .O_POSITION_DETECT(pdet)
    );

    pdic_sensor_model i_pdic_sensor_model (
        .i_clk(clk), .i_target(target), .i_bounce(bounce),
        .o_level(sensor)
    );

    always #50 clk = ~clk;

    // Event pulses are counted where they are settled.
    always @(negedge clk) begin
        if (wsync === 1'b1) begin
            ws_cnt++;
        end
        if (pdet === 1'b1) begin
            pd_cnt++;
        end
    end

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Pready, read data and error are taken at the rising edge that
    // completes the access, and only then is the request released.
    task automatic apb(input logic [11:0] a, input logic w,
                       input logic [7:0] d, input logic m);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= {24'h000000, d};
        rmw     <= m;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) begin
            @(posedge clk);
        end
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        rmw     <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        apb(a, 1'b1, d, 1'b0);
    endtask

    task automatic rdchk(input logic [11:0] a, input logic [7:0] e,
                         input logic m, input string what);
        apb(a, 1'b0, 8'h00, m);
        check(what, rd, {24'h000000, e});
    endtask

    // Starts a fresh match of the bank address against v.
    task automatic match_at(input logic [2:0] v);
        bank <= v ^ 3'h1;
        @(posedge clk);
        bank <= v;
        repeat (3) @(posedge clk);
        @(negedge clk);
    endtask

    task automatic step(input logic [2:0] t, input int hold);
        target <= t;
        repeat (hold) @(posedge clk);
    endtask

    task automatic pd_chk(input string what, input int exp);
        check(what, 32'(pd_cnt - n0), 32'(exp));
        n0 = pd_cnt;
    endtask

    task automatic finish_test;
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        finish_test();
    end

    initial begin
        resetn  = 1'b0;
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 12'h000;
        pwdata  = 32'h00000000;
        rmw     = 1'b0;
        bank    = 3'h0;
        ptg     = 1'b0;
        flen    = 2'h0;
        stopped = 1'b0;
        target  = 3'h0;
        bounce  = 1'b0;
        repeat (12) @(posedge clk);
        resetn <= 1'b1;
        rdchk(up_addr, 8'h00, 1'b0, "upper reset");
        rdchk(lo_addr, 8'h00, 1'b0, "lower reset");
        wr(12'h008, 8'hFF);
        check("unmapped error", {31'h0, err}, 32'h1);
        rdchk(12'h008, 8'h00, 1'b0, "unmapped data");
        wr(lo_addr, 8'hA5);
        rdchk(lo_addr, 8'hA5, 1'b0, "lower rw");
        check("mapped error", {31'h0, err}, 32'h0);
        // ------------------------------------------------------------
        // Compare of every code, flag clearing and masking
        // ------------------------------------------------------------
        for (int cv = 0; cv < 8; cv++) begin
            wr(up_addr, {4'h1, 3'(cv), 1'b1});
            match_at(3'(cv));
            check("irq set", {31'h0, irq}, 32'h1);
            rdchk(up_addr, {4'h3, 3'(cv), 1'b1}, 1'b0, "flag");
            wr(up_addr, {4'h3, 3'(cv), 1'b1});
            rdchk(up_addr, {4'h3, 3'(cv), 1'b1}, 1'b0, "keep");
            wr(up_addr, {4'h1, 3'(cv), 1'b1});
            rdchk(up_addr, {4'h1, 3'(cv), 1'b1}, 1'b0, "clr");
            check("irq clear", {31'h0, irq}, 32'h0);
        end
        rdchk(up_addr, 8'h3F, 1'b1, "rmw read");
        rdchk(up_addr, 8'h1F, 1'b0, "plain read");
        wr(up_addr, 8'h05);
        match_at(3'h2);
        check("irq masked", {31'h0, irq}, 32'h0);
        rdchk(up_addr, 8'h25, 1'b0, "masked flag");
        wr(up_addr, 8'h35);
        @(negedge clk);
        check("irq unmasked", {31'h0, irq}, 32'h1);
        wr(up_addr, 8'h18);
        match_at(3'h4);
        rdchk(up_addr, 8'h18, 1'b0, "cmp off");
        check("irq cmp off", {31'h0, irq}, 32'h0);
        // ------------------------------------------------------------
        // Write timing edge selection
        // ------------------------------------------------------------
        for (int s = 0; s < 4; s++) begin
            wr(up_addr, {2'(s), 6'h00});
            n0 = ws_cnt;
            ptg <= 1'b1;
            repeat (4) @(posedge clk);
            check("sync rise", 32'(ws_cnt - n0), 32'(s & 1));
            n0 = ws_cnt;
            ptg <= 1'b0;
            repeat (4) @(posedge clk);
            check("sync fall", 32'(ws_cnt - n0), 32'(s >> 1));
        end
        // ------------------------------------------------------------
        // Position detection polarity, enables and filter
        // ------------------------------------------------------------
        for (int p = 0; p < 4; p++) begin
            wr(lo_addr, {2'(p), 6'h01});
            n0 = pd_cnt;
            step(3'h1, 8);
            pd_chk("detect rise", p & 1);
            step(3'h0, 8);
            pd_chk("detect fall", p >> 1);
        end
        wr(lo_addr, 8'hC2);
        n0 = pd_cnt;
        step(3'h4, 8);
        step(3'h0, 8);
        pd_chk("disabled input", 0);
        step(3'h2, 2);
        step(3'h0, 8);
        pd_chk("bypass glitch", 2);
        wr(lo_addr, 8'hD2);
        n0 = pd_cnt;
        step(3'h2, 2);
        step(3'h0, 12);
        pd_chk("n2 glitch", 0);
        step(3'h2, 12);
        step(3'h0, 12);
        pd_chk("n2 held", 2);
        flen <= 2'h1;
        step(3'h2, 5);
        step(3'h0, 16);
        pd_chk("n3 glitch", 0);
        step(3'h2, 16);
        step(3'h0, 16);
        pd_chk("n3 held", 2);
        bounce <= 1'b1;
        step(3'h2, 20);
        step(3'h0, 20);
        pd_chk("bounce", 2);
        bounce <= 1'b0;
        stopped <= 1'b1;
        step(3'h2, 20);
        step(3'h0, 20);
        pd_chk("clock stopped", 0);
        stopped <= 1'b0;
        flen <= 2'h2;
        step(3'h2, 12);
        step(3'h0, 24);
        pd_chk("n4 glitch", 0);
        step(3'h2, 24);
        step(3'h0, 24);
        pd_chk("n4 held", 2);
        flen <= 2'h3;
        step(3'h2, 28);
        step(3'h0, 40);
        pd_chk("n5 glitch", 0);
        step(3'h2, 40);
        step(3'h0, 40);
        pd_chk("n5 held", 2);
        finish_test();
    end
endmodule
